// ---- design/aph_pkg.sv ----
// Constants shared by the parallel host port, its checker and its bench
package aph_pkg;

    localparam int unsigned DATA_W       = 10;
    localparam int unsigned CREG_W       = 10;

    // Register select values on the two address pins
    localparam logic [1:0]  RSEL_CR0     = 2'h0;
    localparam logic [1:0]  RSEL_CR1     = 2'h1;

    // Control register 0 fields
    localparam int unsigned CR0_EXT_REF  = 0;
    localparam int unsigned CR0_SINGLE   = 1;
    localparam logic [9:0]  CR0_RESET    = 10'h000;

    // Control register 1 fields
    localparam int unsigned CR1_TRIG_LO  = 0;
    localparam int unsigned CR1_TRIG_HI  = 1;
    localparam int unsigned CR1_DV_HIGH  = 2;
    localparam int unsigned CR1_DV_PULSE = 3;
    localparam int unsigned CR1_WR_ONLY  = 4;
    localparam int unsigned CR1_FLUSH    = 5;
    localparam logic [9:0]  CR1_RESET    = 10'h004;

    // Avalon-MM byte offsets
    localparam logic [4:0]  OFS_STATUS   = 5'h00;
    localparam logic [4:0]  OFS_MASK     = 5'h04;
    localparam logic [4:0]  OFS_CTRL     = 5'h08;
    localparam logic [4:0]  OFS_FILL     = 5'h0C;

    // Status and mask bit positions
    localparam int unsigned ST_HOST_WR   = 0;
    localparam int unsigned ST_HOST_RD   = 1;
    localparam int unsigned ST_TRIGGER   = 2;
    localparam int unsigned ST_OVERFLOW  = 3;
    localparam int unsigned ST_W         = 4;
    localparam logic [3:0]  ST_RESET     = 4'h0;
    localparam logic [3:0]  MASK_RESET   = 4'h0;

    // Host access sequencer, Gray coded
    typedef enum logic [1:0] {
        APH_IDLE = 2'b00,
        APH_READ = 2'b01,
        APH_HOLD = 2'b10
    } aph_state_t;

endpackage : aph_pkg

// ---- design/aph_sample_buffer.sv ----
// Flip-flop sample buffer with fill count and registered full flag
`timescale 1ns/10ps
`default_nettype none

module aph_sample_buffer #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned CNT_W = $clog2(DEPTH + 1)
) (
    input  wire logic               sys_clk,
    input  wire logic               srst,
    input  wire logic               flush,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire logic [WIDTH-1:0]   in_data,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output logic [WIDTH-1:0]        out_data,
    output logic [CNT_W-1:0]        fill
);

    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             full_q, full_d;
    logic             push, pop;

    function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
        // Depth need not be a power of two
        bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction

    assign in_ready  = ~full_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_ptr_q];
    assign fill      = cnt_q;
    assign push      = in_valid & ~full_q & ~flush;
    assign pop       = out_ready & out_valid & ~flush;

    always_comb begin
        wr_ptr_d = push ? bump(wr_ptr_q) : wr_ptr_q;
        rd_ptr_d = pop ? bump(rd_ptr_q) : rd_ptr_q;
        cnt_d    = cnt_q + CNT_W'(push) - CNT_W'(pop);
        if (flush) begin
            wr_ptr_d = '0;
            rd_ptr_d = '0;
            cnt_d    = '0;
        end
        full_d   = (cnt_d == CNT_W'(DEPTH));
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
            full_q   <= 1'b0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            cnt_q    <= cnt_d;
            full_q   <= full_d;
        end
    end

    // Storage carries no reset so it maps to plain flops without a mux tree
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

endmodule // aph_sample_buffer

`default_nettype wire

// ---- design/aph_host_port.sv ----
// Parallel host port: pin decode, control registers, data-available, Avalon-MM status
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module aph_host_port #(
    parameter int unsigned DEPTH = 16
) (
    input  wire logic                        sys_clk,
    input  wire logic                        srst,
    // Host pins
    input  wire logic                        select_low_n,
    input  wire logic                        select_high,
    input  wire logic                        strobe_pin,
    input  wire logic                        read_n,
    input  wire logic                        reg_addr_bit0,
    input  wire logic                        reg_addr_bit1,
    input  wire logic [aph_pkg::DATA_W-1:0]  host_data_in,
    output logic [aph_pkg::DATA_W-1:0]       host_data_out,
    output logic                             host_data_oe,
    output logic                             samples_ready,
    // Conversion engine side
    input  wire logic                        sample_valid,
    input  wire logic [aph_pkg::DATA_W-1:0]  sample_data,
    output logic                             sample_ready,
    output logic                             ext_ref_select,
    output logic                             single_conv_mode,
    // Avalon-MM slave
    input  wire logic [4:0]                  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    output logic [31:0]                      avs_readdata,
    output logic                             avs_waitrequest,
    output logic                             irq
);

    localparam int unsigned CNT_W = $clog2(DEPTH + 1);

    function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] code);
        // Codes 0..3 mean one to four buffered samples
        trig_level = CNT_W'(code) + CNT_W'(1);
    endfunction

    // Buffer
    logic                        buf_in_ready;
    logic                        buf_valid;
    logic                        buf_pop;
    logic                        buf_flush;
    logic [aph_pkg::DATA_W-1:0]  buf_data;
    logic [CNT_W-1:0]            buf_fill;
    logic                        sample_ready_q;

    aph_sample_buffer #(
        .WIDTH (aph_pkg::DATA_W),
        .DEPTH (DEPTH),
        .CNT_W (CNT_W)
    ) u_buf (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .flush     (buf_flush),
        .in_valid  (sample_valid),
        .in_ready  (buf_in_ready),
        .in_data   (sample_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop),
        .out_data  (buf_data),
        .fill      (buf_fill)
    );

    // Host access decode
    logic                   selected;
    logic                   wr_only;
    logic                   host_wr;
    logic                   host_rd;
    logic [1:0]             reg_sel;
    logic [aph_pkg::CREG_W-1:0] cr0_q, cr0_d, cr1_q, cr1_d;
    aph_pkg::aph_state_t    state_q, state_d;
    logic [aph_pkg::DATA_W-1:0] dout_q, dout_d;
    logic                   oe_q, oe_d;
    logic                   wr_take;
    logic                   rd_take;

    assign selected = ~select_low_n & select_high;
    assign wr_only  = cr1_q[aph_pkg::CR1_WR_ONLY];
    // Strobe low means write in both modes, so a first write always lands
    assign host_wr  = selected & ~strobe_pin;
    assign host_rd  = selected & (wr_only ? ~read_n : strobe_pin);
    assign reg_sel  = {reg_addr_bit1, reg_addr_bit0};

    assign wr_take  = (state_q == aph_pkg::APH_IDLE) & host_wr;
    assign rd_take  = (state_q == aph_pkg::APH_IDLE) & ~host_wr & host_rd;
    assign buf_pop  = rd_take & buf_valid;
    assign buf_flush = wr_take & (reg_sel == aph_pkg::RSEL_CR1)
                     & host_data_in[aph_pkg::CR1_FLUSH];

    always_comb begin
        state_d = state_q;
        dout_d  = dout_q;
        oe_d    = 1'b0;
        cr0_d   = cr0_q;
        cr1_d   = cr1_q;
        case (state_q)
            aph_pkg::APH_IDLE: begin
                if (host_wr) begin
                    // Bus word goes to the addressed register, with the CR1 flush bit stored as zero
                    if (reg_sel == aph_pkg::RSEL_CR0) begin
                        cr0_d = host_data_in;
                    end else if (reg_sel == aph_pkg::RSEL_CR1) begin
                        cr1_d = host_data_in;
                        cr1_d[aph_pkg::CR1_FLUSH] = 1'b0;
                    end
                    state_d = aph_pkg::APH_HOLD;
                end else if (host_rd) begin
                    // Empty buffer repeats the last word rather than junk
                    if (buf_valid) begin
                        dout_d = buf_data;
                    end
                    oe_d    = 1'b1;
                    state_d = aph_pkg::APH_READ;
                end
            end
            aph_pkg::APH_READ: begin
                // A write strobe ends the read; the bus is released one cycle after the strobe falls
                if (host_rd && !host_wr) begin
                    oe_d = 1'b1;
                end else begin
                    state_d = aph_pkg::APH_IDLE;
                end
            end
            aph_pkg::APH_HOLD: begin
                // One register write per strobe
                if (!host_wr) begin
                    state_d = aph_pkg::APH_IDLE;
                end
            end
            default: begin
                state_d = aph_pkg::APH_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= aph_pkg::APH_IDLE;
            dout_q  <= '0;
            oe_q    <= 1'b0;
            cr0_q   <= aph_pkg::CR0_RESET;
            cr1_q   <= aph_pkg::CR1_RESET;
        end else begin
            state_q <= state_d;
            dout_q  <= dout_d;
            oe_q    <= oe_d;
            cr0_q   <= cr0_d;
            cr1_q   <= cr1_d;
        end
    end

    // Data-available and engine controls
    logic level_now;
    logic level_q, level_d;
    logic dv_q, dv_d;
    logic ext_ref_q, ext_ref_d;
    logic single_q, single_d;

    assign level_now = (buf_fill >= trig_level(
                        cr1_q[aph_pkg::CR1_TRIG_HI:aph_pkg::CR1_TRIG_LO]));

    always_comb begin
        logic active;
        active    = 1'b0;
        level_d   = level_now;
        // Pulse form marks only the crossing; static form follows the level
        if (cr1_q[aph_pkg::CR1_DV_PULSE]) begin
            active = level_now & ~level_q;
        end else begin
            active = level_now;
        end
        dv_d      = cr1_q[aph_pkg::CR1_DV_HIGH] ? active : ~active;
        ext_ref_d = cr0_q[aph_pkg::CR0_EXT_REF];
        single_d  = cr0_q[aph_pkg::CR0_SINGLE];
    end

    // Ready lags the buffer by a cycle; a sample sent into a full buffer sets overflow
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            level_q        <= 1'b0;
            dv_q           <= 1'b0;
            ext_ref_q      <= 1'b0;
            single_q       <= 1'b0;
            sample_ready_q <= 1'b0;
        end else begin
            level_q        <= level_d;
            dv_q           <= dv_d;
            ext_ref_q      <= ext_ref_d;
            single_q       <= single_d;
            sample_ready_q <= buf_in_ready;
        end
    end

    // Avalon-MM slave with one wait state
    logic [aph_pkg::ST_W-1:0] status_q, status_d;
    logic [aph_pkg::ST_W-1:0] mask_q, mask_d;
    logic [aph_pkg::ST_W-1:0] events;
    logic [31:0]              rdata_q, rdata_d;
    logic                     wait_q, wait_d;
    logic                     irq_q, irq_d;
    logic                     acc;
    logic                     avs_req;

    assign avs_req = avs_read | avs_write;
    assign acc     = avs_req & ~wait_q;

    always_comb begin
        events = '0;
        events[aph_pkg::ST_HOST_WR]  = wr_take;
        events[aph_pkg::ST_HOST_RD]  = rd_take;
        events[aph_pkg::ST_TRIGGER]  = level_now & ~level_q;
        // Engine ignored back-pressure and a sample was lost
        events[aph_pkg::ST_OVERFLOW] = sample_valid & ~buf_in_ready;
        status_d = status_q;
        mask_d   = mask_q;
        rdata_d  = rdata_q;
        wait_d   = ~avs_req | ~wait_q;
        if (acc && avs_write) begin
            case (avs_address)
                aph_pkg::OFS_STATUS: begin
                    status_d = status_q & ~avs_writedata[aph_pkg::ST_W-1:0];
                end
                aph_pkg::OFS_MASK: begin
                    mask_d = avs_writedata[aph_pkg::ST_W-1:0];
                end
                default: begin
                    // Control and fill words are read-only
                    status_d = status_q;
                end
            endcase
        end
        // Set beats a simultaneous clear
        status_d = status_d | events;
        // Loaded in the wait cycle so the word already stands when waitrequest drops
        if (avs_req && wait_q) begin
            case (avs_address)
                aph_pkg::OFS_STATUS: begin
                    rdata_d = 32'(status_q);
                end
                aph_pkg::OFS_MASK: begin
                    rdata_d = 32'(mask_q);
                end
                aph_pkg::OFS_CTRL: begin
                    rdata_d = {12'h000, cr1_q, cr0_q};
                end
                aph_pkg::OFS_FILL: begin
                    rdata_d = 32'(buf_fill);
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
        // Registered, so irq trails the status bits by one cycle
        irq_d = |(status_q & mask_q);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            status_q <= aph_pkg::ST_RESET;
            mask_q   <= aph_pkg::MASK_RESET;
            rdata_q  <= 32'h0000_0000;
            wait_q   <= 1'b1;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            rdata_q  <= rdata_d;
            wait_q   <= wait_d;
            irq_q    <= irq_d;
        end
    end

    assign host_data_out    = dout_q;
    assign host_data_oe     = oe_q;
    assign samples_ready    = dv_q;
    assign sample_ready     = sample_ready_q;
    assign ext_ref_select   = ext_ref_q;
    assign single_conv_mode = single_q;
    assign avs_readdata     = rdata_q;
    assign avs_waitrequest  = wait_q;
    assign irq              = irq_q;

endmodule // aph_host_port

`default_nettype wire

// ---- sim/aph_host_port_properties.sv ----
// Checker for the host pins and status bus of the parallel host port
`timescale 1ns/10ps
`default_nettype none
module aph_host_port_chk (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic select_low_n,
    input wire logic select_high,
    input wire logic strobe_pin,
    input wire logic read_n,
    input wire logic reg_addr_bit0,
    input wire logic reg_addr_bit1,
    input wire logic host_data_oe,
    input wire logic samples_ready,
    input wire logic sample_valid,
    input wire logic ext_ref_select,
    input wire logic single_conv_mode,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic sel;
    logic wr0;
    assign sel = !select_low_n && select_high;
    assign wr0 = sel && !strobe_pin && {reg_addr_bit1, reg_addr_bit0} == aph_pkg::RSEL_CR0;
    chk_oe_release: assert property (!sel |=> !host_data_oe)
        else $error("bus driven while deselected");
    chk_write_quiet: assert property (sel && !strobe_pin |=> !host_data_oe)
        else $error("bus driven during a write");
    chk_oe_cause: assert property ($rose(host_data_oe) |-> $past(sel && (strobe_pin || !read_n)))
        else $error("bus driven without a read");
    chk_oe_select: assert property (host_data_oe |-> $past(sel))
        else $error("bus driven without both selects");
    chk_cfg_cause: assert property ($changed({ext_ref_select, single_conv_mode}) |->
        $past(wr0) || $past(wr0, 2) || $past(wr0, 3))
        else $error("reference select moved without a write");
    chk_dv_cause: assert property ($changed(samples_ready) |-> $past(sel) || $past(sel, 2) ||
        $past(sel, 3) || $past(sample_valid, 2) || $past(sample_valid, 3))
        else $error("data available moved without cause");
    chk_wait_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("status bus answer late");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("status bus answer held too long");
    cover property (host_data_oe);
    cover property (sel && !strobe_pin);
    cover property ($rose(samples_ready));
endmodule // aph_host_port_chk
`default_nettype wire

// ---- sim/aph_host_model.sv ----
// Processor bus master that drives the host pins
`timescale 1ns/10ps
`default_nettype none
module aph_host_model (
    input wire logic       sys_clk,
    input wire logic       bus_oe,
    input wire logic [9:0] bus_in,
    output logic           select_low_n,
    output logic           select_high,
    output logic           strobe_pin,
    output logic           read_n,
    output logic           reg_addr_bit0,
    output logic           reg_addr_bit1,
    output logic           hd_oe,
    output logic [9:0]     hd
);
    initial begin
        select_low_n = 1'b1;
        select_high = 1'b0;
        strobe_pin = 1'b1;
        read_n = 1'b1;
        {reg_addr_bit1, reg_addr_bit0} = 2'h3;
        hd_oe = 1'b0;
        hd = 10'h000;
    end
    task automatic desel;
        select_low_n <= 1'b1;
        select_high <= 1'b0;
        hd_oe <= 1'b0;
        strobe_pin <= 1'b1;
        read_n <= 1'b1;
    endtask
    // The bench always opens with this write, since strobe mode is unknown at power-up
    task automatic hwr(input logic [1:0] a, input logic [9:0] d);
        @(posedge sys_clk);
        select_low_n <= 1'b0;
        select_high <= 1'b1;
        strobe_pin <= 1'b0;
        {reg_addr_bit1, reg_addr_bit0} <= a;
        hd <= d;
        hd_oe <= 1'b1;
        @(posedge sys_clk);
        desel();
    endtask
    // Combined mode keeps read_n idle to show it is ignored there
    task automatic hrd(input logic wo, output logic [9:0] q);
        @(posedge sys_clk);
        select_low_n <= 1'b0;
        select_high <= 1'b1;
        read_n <= !wo;
        do begin
            @(posedge sys_clk);
        end while (bus_oe !== 1'b1);
        q = bus_in;
        desel();
    endtask
endmodule // aph_host_model
`default_nettype wire

// ---- sim/aph_host_port_tb.sv ----
// Self-checking bench for the parallel host port
`timescale 1ns/10ps
`default_nettype none
module aph_host_port_tb;
    typedef struct {logic [1:0] a; logic [9:0] d; logic [1:0] cfg;} aph_row_t;
    aph_row_t rows[4] = '{'{2'h0, 10'h001, 2'h1}, '{2'h0, 10'h002, 2'h2},
                          '{2'h2, 10'h3FF, 2'h2}, '{2'h1, 10'h004, 2'h2}};
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        sample_valid = 1'b0;
    logic [9:0]  sample_data = 10'h000;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic        select_low_n, select_high, strobe_pin, read_n, reg_addr_bit0, reg_addr_bit1;
    logic        oe, dv, ext, single, wreq, irq, hd_oe, srdy;
    logic [9:0]  dout, hd, q, c0, c1;
    logic [31:0] r, rdata;
    wire logic [9:0] bus;
    int          fails = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          k;
    // Released host bus shows the inverted last host word, not a kept value
    assign bus = oe ? dout : (hd_oe ? hd : ~hd);
    aph_host_port dut_u (.sys_clk(sys_clk), .srst(srst), .select_low_n(select_low_n),
        .select_high(select_high), .strobe_pin(strobe_pin), .read_n(read_n),
        .reg_addr_bit0(reg_addr_bit0), .reg_addr_bit1(reg_addr_bit1), .host_data_in(bus),
        .host_data_out(dout), .host_data_oe(oe), .samples_ready(dv),
        .sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(srdy),
        .ext_ref_select(ext), .single_conv_mode(single), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(rdata), .avs_waitrequest(wreq), .irq(irq));
    aph_host_model m (.sys_clk(sys_clk), .bus_oe(oe), .bus_in(bus), .select_low_n(select_low_n),
        .select_high(select_high), .strobe_pin(strobe_pin), .read_n(read_n),
        .reg_addr_bit0(reg_addr_bit0), .reg_addr_bit1(reg_addr_bit1), .hd_oe(hd_oe), .hd(hd));
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge sys_clk);
        end while (wreq !== 1'b0);
        r = rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic push(input logic [9:0] d);
        @(posedge sys_clk);
        sample_valid <= 1'b1;
        sample_data <= d;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic print_verdict;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        c0 = 10'h000;
        c1 = 10'h004;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        check({oe, dv, irq, ext}, 4'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            m.hwr(rows[i].a, rows[i].d);
            if (rows[i].a == 2'h0) c0 = rows[i].d;
            if (rows[i].a == 2'h1) c1 = rows[i].d;
            settle();
            check({single, ext}, rows[i].cfg);
            av(1'b0, aph_pkg::OFS_CTRL, 32'h0);
            check(r, {12'h000, c1, c0});
        end
        $display("register table done");
        push(10'h2A5);
        settle();
        check(dv, 1'b1);
        av(1'b0, aph_pkg::OFS_FILL, 32'h0);
        check(r, 32'h1);
        m.hrd(1'b0, q);
        check(q, 10'h2A5);
        settle();
        check({dv, oe}, 2'h0);
        av(1'b0, aph_pkg::OFS_STATUS, 32'h0);
        check(r, 32'h7);
        $display("combined read done");
        av(1'b1, aph_pkg::OFS_MASK, 32'h1);
        settle();
        check(irq, 1'b1);
        av(1'b1, aph_pkg::OFS_STATUS, 32'hF);
        settle();
        check(irq, 1'b0);
        m.hwr(2'h0, c0);
        settle();
        check(irq, 1'b1);
        av(1'b1, aph_pkg::OFS_MASK, 32'h0);
        settle();
        check(irq, 1'b0);
        av(1'b0, 5'h10, 32'h0);
        check(r, 32'h0);
        av(1'b1, aph_pkg::OFS_STATUS, 32'hF);
        $display("interrupt test done");
        m.hwr(2'h1, 10'h000);
        settle();
        check(dv, 1'b1);
        push(10'h155);
        settle();
        check(dv, 1'b0);
        m.hwr(2'h1, 10'h010);
        m.hrd(1'b1, q);
        check(q, 10'h155);
        settle();
        check(dv, 1'b1);
        $display("write-only mode done");
        // Flush, pulse form, active high, trigger level two, back to combined mode
        m.hwr(2'h1, 10'h02D);
        settle();
        push(10'h001);
        settle();
        check(dv, 1'b0);
        push(10'h002);
        k = 0;
        repeat (6) begin
            @(posedge sys_clk);
            k += int'(dv);
        end
        check(k, 32'h1);
        $display("pulse test done");
        repeat (15) push(10'h3C3);
        settle();
        check(srdy, 1'b0);
        av(1'b0, aph_pkg::OFS_FILL, 32'h0);
        check(r, 32'h10);
        av(1'b0, aph_pkg::OFS_STATUS, 32'h0);
        check(r, 32'hF);
        m.hwr(2'h1, 10'h02D);
        settle();
        check(srdy, 1'b1);
        av(1'b0, aph_pkg::OFS_FILL, 32'h0);
        check(r, 32'h0);
        $display("overflow and flush done");
        print_verdict();
    end
endmodule // aph_host_port_tb
bind aph_host_port aph_host_port_chk chk_u (.sys_clk(sys_clk), .srst(srst),
    .select_low_n(select_low_n), .select_high(select_high), .strobe_pin(strobe_pin),
    .read_n(read_n), .reg_addr_bit0(reg_addr_bit0), .reg_addr_bit1(reg_addr_bit1),
    .host_data_oe(host_data_oe), .samples_ready(samples_ready), .sample_valid(sample_valid),
    .ext_ref_select(ext_ref_select), .single_conv_mode(single_conv_mode),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
`default_nettype wire
